// File: verilog/umc_defs.svh
// Purpose: Offsets, field positions, reset values and timing figures of the measurement counter
// Assumes: 32-bit AHB-Lite register words, one aligned word per register
// Notes: Definitions only
`ifndef UMC_DEFS_SVH
`define UMC_DEFS_SVH
`define UMC_OFF_CTRL 8'h00
`define UMC_OFF_TRIG 8'h04
`define UMC_OFF_GATE 8'h08
`define UMC_OFF_AVG 8'h0c
`define UMC_OFF_RESULT 8'h10
`define UMC_OFF_TOTAL 8'h14
`define UMC_OFF_STATUS 8'h18
`define UMC_CTRL_FUNC_LSB 0
`define UMC_CTRL_FUNC_MSB 2
`define UMC_CTRL_SLOPE 3
`define UMC_CTRL_CONT 4
`define UMC_CTRL_JIT 5
`define UMC_STAT_BUSY 0
`define UMC_STAT_DONE 1
`define UMC_STAT_TOTEN 2
`define UMC_GATE_RST 32'h0098_9680
`define UMC_AVG_RST 3'h0
`define UMC_CLK_MHZ 100
`define UMC_HOLD_MS 250
`define UMC_MIN_GATE_MS 1000
`define UMC_PER_MINUTE 32'h0000_003c
`endif

// File: verilog/umc_pkg.sv
// Purpose: Types shared by the measurement counter modules
// Assumes: Nothing beyond SystemVerilog enums
// Notes: Function order matches the 3-bit function field
package umc_pkg;
  typedef enum logic [2:0] {
    FN_CHAN_ONE_FREQUENCY, FN_PER_MINUTE_RATE, FN_GATED_TOTALIZE, FN_RATIO,
    FN_SINGLE_PERIOD, FN_AVERAGED_PERIOD, FN_SINGLE_INTERVAL, FN_AVERAGED_INTERVAL
  } umc_func_t;
  typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_GATE, ST_HOLD} umc_state_t;
endpackage : umc_pkg

// File: verilog/umc_hyst.sv
// Purpose: Turns the two threshold comparator levels of one channel into one pulse per input cycle
// Assumes: Comparator levels are synchronous to sys_clk
// Notes: The edge that fires is chosen by the slope input
`timescale 1ns/100ps
module umc_hyst (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic aboveUpper,
  input wire logic belowLower,
  input wire logic slopeRise,
  output logic evtPulse
);
  logic high_reg;
  logic known_reg;

  // Level only flips on the opposite threshold, so noise on one threshold never recounts
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      high_reg <= 1'b0;
      known_reg <= 1'b0;
      evtPulse <= 1'b0;
    end else begin
      evtPulse <= 1'b0;
      if (aboveUpper && (!high_reg || !known_reg)) begin
        high_reg <= 1'b1;
        known_reg <= 1'b1;
        evtPulse <= known_reg && slopeRise;
      end else if (belowLower && (high_reg || !known_reg)) begin
        high_reg <= 1'b0;
        known_reg <= 1'b1;
        evtPulse <= known_reg && !slopeRise;
      end
    end
  end

  both_levels_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    evtPulse |-> $past(known_reg) && ($past(high_reg) != high_reg)) else $error("pulse without both thresholds");
  one_pulse_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    evtPulse |=> !evtPulse) else $error("double pulse for one crossing");
endmodule : umc_hyst

// File: verilog/umc_jitter.sv
// Purpose: Pseudo-random start delay that dithers averaged interval starts against the clock
// Assumes: Enabled only when the jittered time base is fitted and selected
// Notes: 8-bit maximal LFSR, delay of 0 to 7 cycles
`timescale 1ns/100ps
module umc_jitter (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic enable,
  output logic [2:0] delay
);
  logic [7:0] lfsr_reg;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lfsr_reg <= 8'h01;
      delay <= 3'h0;
    end else begin
      lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
      delay <= enable ? lfsr_reg[2:0] : 3'h0;
    end
  end

  lfsr_alive_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    lfsr_reg != 8'h00) else $error("jitter source stuck at zero");
endmodule : umc_jitter

// File: verilog/umc_counter.sv
// Purpose: Counting core of a universal counter/timer with an AHB-Lite register port
// Assumes: Channel comparator levels synchronous to sys_clk; sys_clk is the 100 MHz reference
// Notes: Zero-wait slave; result latched on the first hold cycle, or copied from the total every cycle in totalize
// Functional notes
// - Hold 250 ms after each measurement's last gate before the next measurement begins.
// - Frequency counts channel A pulses over a time-base gate.
// - Per-minute rate counts like frequency, then multiplies by sixty.
// - Totalize counts A continuously while enabled; B events toggle the enable.
// - Ratio counts A pulses during a gate set by channel B.
// - Timing functions count reference cycles between input-derived boundaries.
// - Single period gates one A cycle; averaged period gates several cycles.
// - Interval starts on an A pulse and stops on a B pulse.
// - Averaged interval accumulates many repetitions and reports their mean.
// - Each input event adds exactly one count.
// - A pulse needs both hysteresis thresholds crossed.
// - Counted source is the input or the time base, by function.
// - Longer gates accumulate proportionally more counts.
// - Optional jitter dithers averaged interval starts against the clock.
// - Changing the function resets the counting logic.
// - Slope picks rising or falling edge as the trigger.
`include "umc_defs.svh"
`timescale 1ns/100ps
module umc_counter
  import umc_pkg::*;
#(
  parameter int unsigned CNT_W = 32,
  parameter int unsigned HOLD_CYC = `UMC_HOLD_MS * `UMC_CLK_MHZ * 1000,
  parameter int unsigned MIN_GATE_CYC = `UMC_MIN_GATE_MS * `UMC_CLK_MHZ * 1000
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic chanAUpper,
  input wire logic chanALower,
  input wire logic chanBUpper,
  input wire logic chanBLower,
  output logic gateOpen
);
  umc_func_t func_reg;
  umc_state_t state_reg, stateNext;
  logic slope_reg, cont_reg, jit_reg, trig_reg, funcChg_reg, done_reg, totEn_reg;
  logic [31:0] gateLen_reg;
  logic [2:0] avgExp_reg, jitWait_reg, jitDelay;
  logic [CNT_W-1:0] eventCnt_reg, oscCnt_reg, result_reg, total_reg;
  logic [31:0] gateCnt_reg, holdCnt_reg;
  logic [7:0] repCnt_reg;
  logic wrPend_reg;
  logic [7:0] wrAddr_reg;
  logic aEvt, bEvt, addrPhase, openEvt, closeEvt, lastRep, startGate, holdEnd;
  logic [31:0] gateTarget, rdVal;

  function automatic logic isTiming(input umc_func_t f);
    isTiming = (f == FN_SINGLE_PERIOD) || (f == FN_AVERAGED_PERIOD) ||
               (f == FN_SINGLE_INTERVAL) || (f == FN_AVERAGED_INTERVAL);
  endfunction : isTiming

  umc_hyst chanAHyst (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .aboveUpper(chanAUpper),
    .belowLower(chanALower),
    .slopeRise(slope_reg),
    .evtPulse(aEvt)
  );
  umc_hyst chanBHyst (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .aboveUpper(chanBUpper),
    .belowLower(chanBLower),
    .slopeRise(slope_reg),
    .evtPulse(bEvt)
  );
  umc_jitter startJitter (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .enable(jit_reg && func_reg == FN_AVERAGED_INTERVAL),
    .delay(jitDelay)
  );

  // Bus slave: always ready, always OKAY; write data applied in the data phase
  assign addrPhase = hsel && htrans[1] && hready;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wrPend_reg <= addrPhase && hwrite;
      if (addrPhase) begin
        wrAddr_reg <= haddr[7:0];
      end
      if (addrPhase && !hwrite) begin
        hrdata <= rdVal;
      end
    end
  end

  always_comb begin
    rdVal = 32'h0000_0000;
    case (haddr[7:0])
      `UMC_OFF_CTRL: rdVal = {26'h0, jit_reg, cont_reg, slope_reg, func_reg};
      `UMC_OFF_GATE: rdVal = gateLen_reg;
      `UMC_OFF_AVG: rdVal = {29'h0, avgExp_reg};
      `UMC_OFF_RESULT: rdVal = 32'(result_reg);
      `UMC_OFF_TOTAL: rdVal = 32'(total_reg);
      `UMC_OFF_STATUS: rdVal = {29'h0, totEn_reg, done_reg, state_reg != ST_IDLE};
      default: rdVal = 32'h0000_0000;
    endcase
  end

  // Control registers
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      func_reg <= FN_CHAN_ONE_FREQUENCY;
      slope_reg <= 1'b1;
      cont_reg <= 1'b0;
      jit_reg <= 1'b0;
      gateLen_reg <= `UMC_GATE_RST;
      avgExp_reg <= `UMC_AVG_RST;
      trig_reg <= 1'b0;
      funcChg_reg <= 1'b0;
    end else begin
      trig_reg <= wrPend_reg && wrAddr_reg == `UMC_OFF_TRIG;
      funcChg_reg <= 1'b0;
      if (wrPend_reg && wrAddr_reg == `UMC_OFF_CTRL) begin
        func_reg <= umc_func_t'(hwdata[`UMC_CTRL_FUNC_MSB:`UMC_CTRL_FUNC_LSB]);
        funcChg_reg <= hwdata[`UMC_CTRL_FUNC_MSB:`UMC_CTRL_FUNC_LSB] != func_reg;
        slope_reg <= hwdata[`UMC_CTRL_SLOPE];
        cont_reg <= hwdata[`UMC_CTRL_CONT];
        jit_reg <= hwdata[`UMC_CTRL_JIT];
      end
      if (wrPend_reg && wrAddr_reg == `UMC_OFF_GATE) begin
        gateLen_reg <= hwdata;
      end
      if (wrPend_reg && wrAddr_reg == `UMC_OFF_AVG) begin
        avgExp_reg <= hwdata[2:0];
      end
    end
  end

  // Gate opening and closing conditions per function
  assign gateTarget = (func_reg == FN_PER_MINUTE_RATE) ? 32'(MIN_GATE_CYC) : gateLen_reg;
  assign lastRep = repCnt_reg == 8'((9'h001 << avgExp_reg) - 9'h001);
  assign holdEnd = state_reg == ST_HOLD && holdCnt_reg >= 32'(HOLD_CYC - 1);
  assign startGate = (state_reg == ST_IDLE && stateNext == ST_ARM) || (holdEnd && cont_reg);

  always_comb begin
    case (func_reg)
      FN_CHAN_ONE_FREQUENCY, FN_PER_MINUTE_RATE: begin
        openEvt = 1'b1;
        closeEvt = gateCnt_reg + 32'h1 >= gateTarget;
      end
      FN_RATIO: begin
        openEvt = bEvt;
        closeEvt = bEvt;
      end
      FN_SINGLE_PERIOD: begin
        openEvt = aEvt;
        closeEvt = aEvt;
      end
      FN_AVERAGED_PERIOD: begin
        openEvt = aEvt;
        closeEvt = aEvt && lastRep;
      end
      FN_SINGLE_INTERVAL, FN_AVERAGED_INTERVAL: begin
        openEvt = aEvt && jitWait_reg == 3'h0;
        closeEvt = bEvt;
      end
      default: begin
        openEvt = 1'b0;
        closeEvt = 1'b0;
      end
    endcase
  end

  always_comb begin
    stateNext = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (func_reg != FN_GATED_TOTALIZE && (cont_reg || trig_reg)) begin
          stateNext = ST_ARM;
        end
      end
      ST_ARM: begin
        if (openEvt) begin
          stateNext = ST_GATE;
        end
      end
      ST_GATE: begin
        if (closeEvt) begin
          // Averaged interval rearms between repetitions and keeps its sums
          stateNext = (func_reg == FN_AVERAGED_INTERVAL && !lastRep) ? ST_ARM : ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (holdEnd) begin
          stateNext = cont_reg ? ST_ARM : ST_IDLE;
        end
      end
      default: stateNext = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      gateOpen <= 1'b0;
    end else if (funcChg_reg) begin
      state_reg <= ST_IDLE;
      gateOpen <= 1'b0;
    end else begin
      state_reg <= stateNext;
      gateOpen <= stateNext == ST_GATE;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      holdCnt_reg <= 32'h0;
    end else if (state_reg == ST_HOLD && !funcChg_reg) begin
      holdCnt_reg <= holdCnt_reg + 32'h1;
    end else begin
      holdCnt_reg <= 32'h0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      jitWait_reg <= 3'h0;
    end else if (state_reg != ST_ARM) begin
      jitWait_reg <= jitDelay;
    end else if (jitWait_reg != 3'h0) begin
      jitWait_reg <= jitWait_reg - 3'h1;
    end
  end

  // Measurement counters
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      eventCnt_reg <= '0;
      oscCnt_reg <= '0;
      gateCnt_reg <= 32'h0;
      repCnt_reg <= 8'h00;
    end else if (startGate || funcChg_reg) begin
      eventCnt_reg <= '0;
      oscCnt_reg <= '0;
      gateCnt_reg <= 32'h0;
      repCnt_reg <= 8'h00;
    end else if (state_reg == ST_GATE) begin
      gateCnt_reg <= gateCnt_reg + 32'h1;
      if (isTiming(func_reg)) begin
        oscCnt_reg <= oscCnt_reg + 1'b1;
      end else if (aEvt) begin
        eventCnt_reg <= eventCnt_reg + 1'b1;
      end
      if ((func_reg == FN_AVERAGED_PERIOD && aEvt) || (func_reg == FN_AVERAGED_INTERVAL && bEvt)) begin
        repCnt_reg <= repCnt_reg + 8'h01;
      end
    end
  end

  // Totalize: B events toggle counting, total is live
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      totEn_reg <= 1'b0;
      total_reg <= '0;
    end else if (funcChg_reg || func_reg != FN_GATED_TOTALIZE) begin
      totEn_reg <= 1'b0;
      total_reg <= '0;
    end else begin
      if (bEvt) begin
        totEn_reg <= !totEn_reg;
      end
      if (aEvt && totEn_reg) begin
        total_reg <= total_reg + 1'b1;
      end
    end
  end

  // Result latched on the first hold cycle, after the closing count has settled; totalize copies the total every cycle
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      result_reg <= '0;
    end else if (func_reg == FN_GATED_TOTALIZE) begin
      result_reg <= total_reg;
    end else if (state_reg == ST_HOLD && holdCnt_reg == 32'h0) begin
      case (func_reg)
        FN_PER_MINUTE_RATE: result_reg <= CNT_W'(eventCnt_reg * `UMC_PER_MINUTE);
        FN_AVERAGED_PERIOD, FN_AVERAGED_INTERVAL: result_reg <= oscCnt_reg >> avgExp_reg;
        FN_SINGLE_PERIOD, FN_SINGLE_INTERVAL: result_reg <= oscCnt_reg;
        default: result_reg <= eventCnt_reg;
      endcase
    end
  end

  // Done is set by a new result and cleared by reading it; set wins
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      done_reg <= 1'b0;
    end else if (state_reg == ST_HOLD && holdCnt_reg == 32'h0) begin
      done_reg <= 1'b1;
    end else if (addrPhase && !hwrite && haddr[7:0] == `UMC_OFF_RESULT) begin
      done_reg <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence gateOpensS;
    state_reg == ST_ARM && openEvt && !funcChg_reg && func_reg != FN_AVERAGED_INTERVAL;
  endsequence
  sequence timedGateS;
    gateOpensS ##1 (state_reg == ST_GATE && isTiming(func_reg) && !closeEvt && !funcChg_reg);
  endsequence

  hold_length_a: assert property (state_reg == ST_HOLD && !holdEnd && !funcChg_reg |=> state_reg == ST_HOLD)
    else $error("hold left early");
  freq_count_a: assert property (state_reg == ST_GATE && func_reg == FN_CHAN_ONE_FREQUENCY && aEvt && !funcChg_reg
    |=> eventCnt_reg == $past(eventCnt_reg) + 1'b1) else $error("frequency pulse missed");
  minute_scale_a: assert property (state_reg == ST_HOLD && holdCnt_reg == 32'h1 && func_reg == FN_PER_MINUTE_RATE
    |-> result_reg == CNT_W'(eventCnt_reg * `UMC_PER_MINUTE)) else $error("per minute scaling wrong");
  total_live_a: assert property (func_reg == FN_GATED_TOTALIZE && totEn_reg && aEvt && !funcChg_reg
    |=> total_reg == $past(total_reg) + 1'b1 ##1 result_reg == $past(total_reg)) else $error("total not live");
  ratio_close_a: assert property (state_reg == ST_GATE && func_reg == FN_RATIO && bEvt && !funcChg_reg
    |=> state_reg == ST_HOLD) else $error("ratio gate not closed by B");
  osc_count_a: assert property (timedGateS |=> oscCnt_reg == 1 && eventCnt_reg == 0)
    else $error("reference cycles not counted");
  period_close_a: assert property (state_reg == ST_GATE && func_reg == FN_SINGLE_PERIOD && aEvt && !funcChg_reg
    |=> state_reg == ST_HOLD ##1 result_reg == $past(oscCnt_reg)) else $error("period gate wrong");
  interval_stop_a: assert property (state_reg == ST_GATE && func_reg == FN_SINGLE_INTERVAL && !bEvt && !funcChg_reg
    |=> state_reg == ST_GATE) else $error("interval closed without stop");
  avg_rearm_a: assert property (state_reg == ST_GATE && func_reg == FN_AVERAGED_INTERVAL && bEvt && !lastRep
    && !funcChg_reg |=> state_reg == ST_ARM && oscCnt_reg == $past(oscCnt_reg) + 1'b1) else $error("average lost");
  func_reset_a: assert property (funcChg_reg |=> state_reg == ST_IDLE && oscCnt_reg == 0 && !gateOpen)
    else $error("function change did not reset");
  gate_clear_a: assert property (gateOpensS |=> gateOpen && oscCnt_reg == 0 && eventCnt_reg == 0)
    else $error("counters not clear at gate start");
  single_shot_a: assert property (state_reg == ST_IDLE && !cont_reg && !trig_reg |=> state_reg == ST_IDLE)
    else $error("measurement started without trigger");
endmodule : umc_counter

// File: sim/umc_sig_model.sv
// Purpose: Comparator pair of one input channel, as the signal conditioner presents it
// Assumes: Tasks are called just after a rising edge of sys_clk
// Notes: The input idles below the lower threshold; both comparators are never high together
`timescale 1ns/100ps
module umc_sig_model (
  input wire logic sys_clk,
  output logic aboveUpper,
  output logic belowLower
);
  initial begin
    aboveUpper = 1'b0;
    belowLower = 1'b1;
  end

  task automatic lvl(input logic up, input logic low, input int n);
    aboveUpper <= up;
    belowLower <= low;
    repeat (n) @(posedge sys_clk);
  endtask : lvl

  // Full swing through both thresholds, period 2*h+2 clocks
  task automatic cyc(input int h);
    lvl(1'b0, 1'b0, 1);
    lvl(1'b1, 1'b0, h);
    lvl(1'b0, 1'b0, 1);
    lvl(1'b0, 1'b1, h);
  endtask : cyc

  // Ringing about the upper threshold; the lower one is reached only at the end
  task automatic wiggle(input int n);
    lvl(1'b0, 1'b0, 1);
    repeat (n) begin
      lvl(1'b1, 1'b0, 2);
      lvl(1'b0, 1'b0, 1);
    end
    lvl(1'b0, 1'b1, 2);
  endtask : wiggle
endmodule : umc_sig_model

// File: sim/tb.sv
// Purpose: Self-checking bench for the measurement counter through its register port
// Assumes: Zero-wait slave; shortened hold and per-minute gate counts
// Notes: Every task starts and ends just after a rising clock edge
`timescale 1ns/100ps
`include "umc_defs.svh"
`define TB_CHK(got, exp, what) begin \
  testsRun++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("ERROR t=%0t %s: got %0h expected %0h", $time, what, got, exp); \
  end \
end
module tb;
  import umc_pkg::*;
  localparam int HOLD = 20;
  localparam int MINGATE = 200;
  logic sys_clk, sys_rst, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, gateOpen;
  logic aUp, aLow, bUp, bLow;
  int failures = 0;
  int testsRun = 0;
  int gateCnt, n;

  umc_counter #(.HOLD_CYC(HOLD), .MIN_GATE_CYC(MINGATE)) uut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .chanAUpper(aUp), .chanALower(aLow),
    .chanBUpper(bUp), .chanBLower(bLow), .gateOpen(gateOpen)
  );
  umc_sig_model chA (.sys_clk(sys_clk), .aboveUpper(aUp), .belowLower(aLow));
  umc_sig_model chB (.sys_clk(sys_clk), .aboveUpper(bUp), .belowLower(bLow));

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (gateOpen === 1'b1) gateCnt++;

  task automatic xfer(input logic wr, input logic [7:0] off, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, off};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    `TB_CHK(hresp, 1'b0, "bus response")
  endtask : xfer

  task automatic wr(input logic [7:0] off, input logic [31:0] d);
    logic [31:0] dummy;
    xfer(1'b1, off, d, dummy);
  endtask : wr

  task automatic chkRd(input logic [7:0] off, input logic [31:0] exp, input string what);
    xfer(1'b0, off, 32'h0, rdv);
    `TB_CHK(rdv, exp, what)
  endtask : chkRd

  // Function write, then let the internal reset land before anything else
  task automatic setup(input logic [31:0] ctrl, input logic trig);
    wr(`UMC_OFF_CTRL, ctrl);
    repeat (3) @(posedge sys_clk);
    gateCnt = 0;
    if (trig) wr(`UMC_OFF_TRIG, 32'h1);
    repeat (3) @(posedge sys_clk);
  endtask : setup

  task automatic waitLevel(input logic v, output int cnt);
    cnt = 0;
    while (gateOpen !== v && cnt < 2000) begin
      @(posedge sys_clk);
      cnt++;
    end
    if (cnt >= 2000) `TB_CHK(gateOpen, v, "gate level never reached")
  endtask : waitLevel

  task automatic waitDone;
    int k;
    rdv = 32'h0;
    for (k = 0; k < 300 && rdv[`UMC_STAT_DONE] !== 1'b1; k++) xfer(1'b0, `UMC_OFF_STATUS, 32'h0, rdv);
    `TB_CHK(rdv[`UMC_STAT_DONE], 1'b1, "result ready")
    xfer(1'b0, `UMC_OFF_RESULT, 32'h0, rdv);
  endtask : waitDone

  task automatic endTest(input string name);
    repeat (HOLD + 5) @(posedge sys_clk);
    $display("Test %s finished: %0d checks, %0d mismatches", name, testsRun, failures);
  endtask : endTest

  task automatic interval(input logic [31:0] ctrl, input int d, input int reps);
    setup(ctrl, 1'b1);
    repeat (reps) begin
      // Lets any start jitter run out before the A edge arrives
      repeat (8) @(posedge sys_clk);
      fork
        chA.cyc(2);
        begin
          repeat (d) @(posedge sys_clk);
          chB.cyc(6);
        end
      join
      repeat (3) @(posedge sys_clk);
    end
    waitDone();
  endtask : interval

  task automatic stop_test;
    $display("Checks made: %0d, mismatches: %0d", testsRun, failures);
    if (failures == 0 && testsRun > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (60000) @(posedge sys_clk);
    failures++;
    stop_test();
  end

  initial begin
    logic [7:0] zeroOffs [5];
    zeroOffs = '{`UMC_OFF_AVG, `UMC_OFF_RESULT, `UMC_OFF_TOTAL, `UMC_OFF_STATUS, 8'h1c};
    sys_clk = 1'b0;
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    gateCnt = 0;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    chkRd(`UMC_OFF_CTRL, 32'h0000_0008, "ctrl after reset");
    chkRd(`UMC_OFF_GATE, `UMC_GATE_RST, "gate after reset");
    wr(8'h1c, 32'hffff_ffff);
    foreach (zeroOffs[i]) chkRd(zeroOffs[i], 32'h0, "zero after reset or unmapped");
    // Comparators ignore the first threshold level seen after reset, so swing both once while idle
    fork
      chA.cyc(2);
      chB.cyc(2);
    join
    endTest("reset");
    wr(`UMC_OFF_GATE, 32'd150);
    setup(32'h08, 1'b1);
    waitLevel(1'b1, n);
    repeat (3) chA.wiggle(3);
    repeat (4) chA.cyc(2);
    waitLevel(1'b0, n);
    `TB_CHK(gateCnt, 150, "frequency gate length")
    waitDone();
    `TB_CHK(rdv, 32'd7, "frequency count")
    endTest("frequency");
    chkRd(`UMC_OFF_STATUS, 32'h0, "idle after single run");
    `TB_CHK(gateCnt, 150, "no second gate in single mode")
    setup(32'h09, 1'b1);
    waitLevel(1'b1, n);
    repeat (5) chA.cyc(2);
    waitDone();
    `TB_CHK(rdv, 32'd300, "per-minute result")
    `TB_CHK(gateCnt, MINGATE, "per-minute gate length")
    endTest("per_minute");
    setup(32'h0b, 1'b1);
    chB.cyc(2);
    repeat (4) chA.cyc(2);
    chB.cyc(2);
    waitDone();
    `TB_CHK(rdv, 32'd4, "ratio count")
    endTest("ratio");
    wr(`UMC_OFF_AVG, 32'h0);
    setup(32'h0c, 1'b1);
    repeat (3) chA.cyc(4);
    waitDone();
    `TB_CHK(rdv, 32'd10, "single period")
    endTest("period");
    wr(`UMC_OFF_AVG, 32'h2);
    setup(32'h0d, 1'b1);
    repeat (6) chA.cyc(4);
    waitDone();
    `TB_CHK(rdv, 32'd10, "averaged period")
    endTest("avg_period");
    interval(32'h0e, 12, 1);
    `TB_CHK(rdv, 32'd12, "single interval")
    wr(`UMC_OFF_AVG, 32'h1);
    interval(32'h0f, 12, 2);
    `TB_CHK(rdv, 32'd12, "averaged interval")
    // Falling slope: the start comes 3 clocks after the rise, the stop 7 clocks after it
    interval(32'h06, 12, 1);
    `TB_CHK(rdv, 32'd16, "interval on falling slope")
    interval(32'h2f, 12, 2);
    `TB_CHK(rdv, 32'd12, "jittered averaged interval")
    endTest("interval");
    setup(32'h0a, 1'b0);
    chB.cyc(2);
    xfer(1'b0, `UMC_OFF_STATUS, 32'h0, rdv);
    `TB_CHK(rdv[`UMC_STAT_TOTEN], 1'b1, "totalize enabled by B")
    repeat (3) chA.cyc(2);
    chkRd(`UMC_OFF_TOTAL, 32'd3, "running total");
    wr(`UMC_OFF_TRIG, 32'h1);
    xfer(1'b0, `UMC_OFF_STATUS, 32'h0, rdv);
    `TB_CHK(rdv[`UMC_STAT_BUSY], 1'b0, "trigger ignored in totalize")
    chB.cyc(2);
    repeat (2) chA.cyc(2);
    chkRd(`UMC_OFF_TOTAL, 32'd3, "total frozen when disabled");
    endTest("totalize");
    wr(`UMC_OFF_GATE, 32'd10);
    setup(32'h18, 1'b1);
    waitLevel(1'b1, n);
    waitLevel(1'b0, n);
    waitLevel(1'b1, n);
    `TB_CHK(n >= HOLD, 1'b1, "hold before next gate")
    `TB_CHK(n <= HOLD + 4, 1'b1, "continuous restart")
    setup(32'h09, 1'b0);
    gateCnt = 0;
    xfer(1'b0, `UMC_OFF_STATUS, 32'h0, rdv);
    `TB_CHK(rdv[`UMC_STAT_BUSY], 1'b0, "function change aborts")
    repeat (3 * HOLD) @(posedge sys_clk);
    `TB_CHK(gateCnt, 0, "no gate after abort")
    endTest("continuous");
    stop_test();
  end
endmodule : tb
